// file: hw/ccdt_cfg.svh
// Constants for the completion cache discard timer: offsets, widths, reset values.
// Assumes it is included by bare name from the package and the timer module.
`ifndef CCDT_CFG_SVH
`define CCDT_CFG_SVH

`define CCDT_OFF_START_LIMIT  8'hea
`define CCDT_OFF_MIN_CYCLES   8'hec
`define CCDT_OFF_MAX_CYCLES   8'hee

`define CCDT_START_W          8
`define CCDT_TIMER_W          12

`define CCDT_START_RST        8'h08
`define CCDT_MIN_RST          12'h07f
`define CCDT_MAX_RST          12'h1c0

`define CCDT_MODE_NO_CACHE    2'b00

`endif

// file: hw/ccdt_pkg.sv
// Types shared by the completion cache discard timer modules.
// Assumes ccdt_cfg.svh is on the include path.
`include "ccdt_cfg.svh"

package ccdt_pkg;

    typedef struct packed {
        logic        req;
        logic        wr;
        logic [7:0]  addr;
        logic [1:0]  be;
        logic [15:0] wdata;
    } cfg_access_t;

    typedef struct packed {
        logic cycle_start;
        logic read_hit;
        logic data_returned;
        logic cache_valid;
    } cache_event_t;

    typedef enum logic [1:0] {
        ST_EMPTY   = 2'b00,
        ST_HOLD    = 2'b01,
        ST_DISCARD = 2'b10,
        ST_DRAIN   = 2'b11
    } hold_state_t;

endpackage

// file: hw/completion_cache_discard_timer.sv
// Discard decision for cached read-completion data, with its three limit registers.
// Assumes config accesses and cache events come from logic on core_clk;
// the two reset pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "ccdt_cfg.svh"

// Summary of operation
// - Count cycle starts without read hit; discard allowed at 8-bit limit, default 8.
// - Count check fires only after 12-bit minimum idle cycles, default 127.
// - Discard whatever the count after 12-bit maximum idle cycles, except in mode 00; default 448.
// - Upper byte of cycle-start limit register reads zero.
// - Top four bits of both cycle limit registers read zero.
// - Fundamental, global or power-on reset restore defaults; hot reset does not.
// - Mode 00 disables caching; leftover data dropped once any data returned.
module completion_cache_discard_timer
    import ccdt_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    input  wire logic         pcie_fund_reset_b,
    input  wire logic         global_reset_input_b,
    input  wire logic [1:0]   completion_caching_policy,
    input  wire cache_event_t cache_evt,
    input  wire cfg_access_t  cfg_in,
    output logic [15:0]       cfg_rdata_ff,
    output logic              cfg_ack_ff,
    output logic              discard_ff
);

    // Reset pin synchronisers
    logic [2:0] fund_sync_ff;
    logic [2:0] glob_sync_ff;
    logic       fund_filt_ff;
    logic       glob_filt_ff;
    logic [2:0] nxt_fund_sync;
    logic [2:0] nxt_glob_sync;
    logic       nxt_fund_filt;
    logic       nxt_glob_filt;
    logic       limit_reset;

    always_comb
    begin
        nxt_fund_sync = {fund_sync_ff[1:0], pcie_fund_reset_b};
        nxt_glob_sync = {glob_sync_ff[1:0], global_reset_input_b};
        nxt_fund_filt = fund_filt_ff;
        nxt_glob_filt = glob_filt_ff;
        if (fund_sync_ff[1] == fund_sync_ff[2])
            nxt_fund_filt = fund_sync_ff[2];
        if (glob_sync_ff[1] == glob_sync_ff[2])
            nxt_glob_filt = glob_sync_ff[2];
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fund_sync_ff <= 3'h7;
            glob_sync_ff <= 3'h7;
            fund_filt_ff <= 1'b1;
            glob_filt_ff <= 1'b1;
        end
        else
        begin
            fund_sync_ff <= nxt_fund_sync;
            glob_sync_ff <= nxt_glob_sync;
            fund_filt_ff <= nxt_fund_filt;
            glob_filt_ff <= nxt_glob_filt;
        end
    end

    // No hot reset input: the limits deliberately survive it
    assign limit_reset = !fund_filt_ff || !glob_filt_ff;

    // Limit registers and config port
    logic [`CCDT_START_W-1:0] start_lim_ff;
    logic [`CCDT_TIMER_W-1:0] min_lim_ff;
    logic [`CCDT_TIMER_W-1:0] max_lim_ff;
    logic [`CCDT_START_W-1:0] nxt_start_lim;
    logic [`CCDT_TIMER_W-1:0] nxt_min_lim;
    logic [`CCDT_TIMER_W-1:0] nxt_max_lim;
    logic [15:0]              nxt_rdata;
    logic                     nxt_ack;
    logic                     cfg_wr_en;
    assign cfg_wr_en = cfg_in.req && cfg_in.wr;

    always_comb
    begin
        nxt_start_lim = start_lim_ff;
        nxt_min_lim   = min_lim_ff;
        nxt_max_lim   = max_lim_ff;
        nxt_ack       = cfg_in.req;
        nxt_rdata     = 16'h0000;
        if (limit_reset)
        begin
            nxt_start_lim = `CCDT_START_RST;
            nxt_min_lim   = `CCDT_MIN_RST;
            nxt_max_lim   = `CCDT_MAX_RST;
        end
        else if (cfg_wr_en && (cfg_in.addr == `CCDT_OFF_START_LIMIT))
        begin
            if (cfg_in.be[0])
                nxt_start_lim = cfg_in.wdata[7:0];
        end
        else if (cfg_wr_en && (cfg_in.addr == `CCDT_OFF_MIN_CYCLES))
        begin
            if (cfg_in.be[0])
                nxt_min_lim[7:0] = cfg_in.wdata[7:0];
            if (cfg_in.be[1])
                nxt_min_lim[11:8] = cfg_in.wdata[11:8];
        end
        else if (cfg_wr_en && (cfg_in.addr == `CCDT_OFF_MAX_CYCLES))
        begin
            if (cfg_in.be[0])
                nxt_max_lim[7:0] = cfg_in.wdata[7:0];
            if (cfg_in.be[1])
                nxt_max_lim[11:8] = cfg_in.wdata[11:8];
        end
        if (cfg_in.req && !cfg_in.wr && (cfg_in.addr == `CCDT_OFF_START_LIMIT))
            nxt_rdata = {8'h00, start_lim_ff};
        else if (cfg_in.req && !cfg_in.wr && (cfg_in.addr == `CCDT_OFF_MIN_CYCLES))
            nxt_rdata = {4'h0, min_lim_ff};
        else if (cfg_in.req && !cfg_in.wr && (cfg_in.addr == `CCDT_OFF_MAX_CYCLES))
            nxt_rdata = {4'h0, max_lim_ff};
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            start_lim_ff <= `CCDT_START_RST;
            min_lim_ff   <= `CCDT_MIN_RST;
            max_lim_ff   <= `CCDT_MAX_RST;
            cfg_rdata_ff <= 16'h0000;
            cfg_ack_ff   <= 1'b0;
        end
        else
        begin
            start_lim_ff <= nxt_start_lim;
            min_lim_ff   <= nxt_min_lim;
            max_lim_ff   <= nxt_max_lim;
            cfg_rdata_ff <= nxt_rdata;
            cfg_ack_ff   <= nxt_ack;
        end
    end

    // Idle-gap counters
    hold_state_t              state_ff;
    hold_state_t              nxt_state;
    logic                     nxt_discard;
    logic                     holding;
    logic                     cnt_clr;
    logic                     start_reached;
    logic                     min_reached;
    logic                     max_reached;
    logic [`CCDT_START_W-1:0] start_cnt;
    logic [`CCDT_TIMER_W-1:0] min_cnt;
    logic [`CCDT_TIMER_W-1:0] max_cnt;
    logic                     caching_off;
    logic                     timer_discard;

    assign holding     = (state_ff == ST_HOLD);
    assign cnt_clr     = cache_evt.read_hit || !holding;
    assign caching_off = (completion_caching_policy == `CCDT_MODE_NO_CACHE);

    hit_gap_counter #(.WIDTH(`CCDT_START_W)) u_start_cnt (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clr      (cnt_clr),
        .inc      (cache_evt.cycle_start),
        .limit    (start_lim_ff),
        .count    (start_cnt),
        .reached  (start_reached)
    );
    hit_gap_counter #(.WIDTH(`CCDT_TIMER_W)) u_min_cnt (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clr      (cnt_clr),
        .inc      (1'b1),
        .limit    (min_lim_ff),
        .count    (min_cnt),
        .reached  (min_reached)
    );
    hit_gap_counter #(.WIDTH(`CCDT_TIMER_W)) u_max_cnt (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clr      (cnt_clr),
        .inc      (1'b1),
        .limit    (max_lim_ff),
        .count    (max_cnt),
        .reached  (max_reached)
    );
    // upper expiry or count after lower
    assign timer_discard = !cache_evt.read_hit
                           && (max_reached || (min_reached && start_reached));

    always_comb
    begin
        nxt_state   = state_ff;
        nxt_discard = 1'b0;
        case (state_ff)
            ST_EMPTY:
                if (cache_evt.cache_valid)
                    nxt_state = ST_HOLD;
            ST_HOLD:
                if (!cache_evt.cache_valid)
                    nxt_state = ST_EMPTY;
                else if (caching_off ? cache_evt.data_returned : timer_discard)
                begin
                    nxt_state   = ST_DISCARD;
                    nxt_discard = 1'b1;
                end
            ST_DISCARD:
                nxt_state = ST_DRAIN;
            ST_DRAIN:
                // Wait for the buffer to empty so one hold never discards twice
                if (!cache_evt.cache_valid)
                    nxt_state = ST_EMPTY;
            default:
                nxt_state = ST_EMPTY;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff   <= ST_EMPTY;
            discard_ff <= 1'b0;
        end
        else
        begin
            state_ff   <= nxt_state;
            discard_ff <= nxt_discard;
        end
    end

    // Checks
    AST_START_DISCARD: assert property (@(posedge core_clk) disable iff (!rst_b)
        holding && cache_evt.cache_valid && !caching_off && !cache_evt.read_hit
        && min_reached && (start_cnt >= start_lim_ff) |=> discard_ff)
        else $error("count limit reached after lower timer without discard");
    AST_MIN_GATES_COUNT: assert property (@(posedge core_clk) disable iff (!rst_b)
        discard_ff && !$past(caching_off) && !$past(max_reached)
        |-> $past(min_cnt) >= $past(min_lim_ff))
        else $error("count discard before lower timer expired");
    AST_MAX_DISCARD: assert property (@(posedge core_clk) disable iff (!rst_b)
        holding && cache_evt.cache_valid && !caching_off && !cache_evt.read_hit
        && (max_cnt >= max_lim_ff) |=> discard_ff ##1 (state_ff == ST_DRAIN))
        else $error("upper timer expired without discard");
    AST_START_UPPER_ZERO: assert property (@(posedge core_clk) disable iff (!rst_b)
        cfg_in.req && !cfg_in.wr && (cfg_in.addr == `CCDT_OFF_START_LIMIT)
        |=> cfg_ack_ff && (cfg_rdata_ff[15:8] == 8'h00))
        else $error("cycle-start limit upper byte not zero");
    AST_TIMER_NIBBLE_ZERO: assert property (@(posedge core_clk) disable iff (!rst_b)
        cfg_in.req && !cfg_in.wr && ((cfg_in.addr == `CCDT_OFF_MIN_CYCLES)
        || (cfg_in.addr == `CCDT_OFF_MAX_CYCLES)) |=> cfg_rdata_ff[15:12] == 4'h0)
        else $error("timer limit top nibble not zero");
    AST_LIMIT_DEFAULTS: assert property (@(posedge core_clk) disable iff (!rst_b)
        limit_reset |=> (start_lim_ff == `CCDT_START_RST) && (min_lim_ff == `CCDT_MIN_RST)
        && (max_lim_ff == `CCDT_MAX_RST))
        else $error("limits not restored by reset");
    AST_NO_CACHE_DROP: assert property (@(posedge core_clk) disable iff (!rst_b)
        holding && cache_evt.cache_valid && caching_off && cache_evt.data_returned
        |=> discard_ff)
        else $error("no-cache mode kept data after return");
    AST_HIT_RESTART: assert property (@(posedge core_clk) disable iff (!rst_b)
        cache_evt.read_hit |=> (start_cnt == 8'h00) && (min_cnt == 12'h000)
        && (max_cnt == 12'h000) && (!discard_ff || $past(caching_off)))
        else $error("read hit did not restart counters");
    AST_DISCARD_PULSE: assert property (@(posedge core_clk) disable iff (!rst_b)
        discard_ff |=> !discard_ff)
        else $error("discard longer than one cycle");

    COV_MAX_DISCARD: cover property (@(posedge core_clk) disable iff (!rst_b)
        discard_ff && $past(max_reached) && !$past(caching_off));
    COV_COUNT_DISCARD: cover property (@(posedge core_clk) disable iff (!rst_b)
        discard_ff && !$past(max_reached) && !$past(caching_off));
    COV_NO_CACHE: cover property (@(posedge core_clk) disable iff (!rst_b)
        discard_ff && $past(caching_off));
    COV_CFG_READ: cover property (@(posedge core_clk) disable iff (!rst_b)
        cfg_ack_ff && (cfg_rdata_ff != 16'h0000));

endmodule

`default_nettype wire

// file: hw/hit_gap_counter.sv
// Saturating counter of events since the last clear, with a limit compare.
// Assumes clr and inc come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module hit_gap_counter #(
    parameter int WIDTH = 12
) (
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic             clr,
    input  wire logic             inc,
    input  wire logic [WIDTH-1:0] limit,
    output logic      [WIDTH-1:0] count,
    output logic                  reached
);

    logic [WIDTH-1:0] count_ff;
    logic [WIDTH-1:0] nxt_count;

    always_comb
    begin
        nxt_count = count_ff;
        if (clr)
            nxt_count = '0;
        // Saturate so a long idle gap never wraps back below the limit
        else if (inc && (count_ff != {WIDTH{1'b1}}))
            nxt_count = count_ff + 1'b1;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            count_ff <= '0;
        else
            count_ff <= nxt_count;
    end

    assign count   = count_ff;
    assign reached = (count_ff >= limit);

endmodule

`default_nettype wire

// file: tb/pci_master_model.sv
// Model of the subordinate PCI masters as seen by the discard timer: cache events.
// Assumes the bench calls its tasks at the falling edge of core_clk.
`timescale 1ns/1ps
`default_nettype none

module pci_master_model
    import ccdt_pkg::*;
(
    input  wire logic      core_clk,
    output var cache_event_t cache_evt
);
    initial cache_evt = '0;

    task automatic set_valid(input logic v);
        cache_evt.cache_valid = v;
    endtask

    // One-cycle pulses; the buffer level is left as it stands
    task automatic pulse(input logic s, input logic h, input logic r);
        cache_evt.cycle_start   = s;
        cache_evt.read_hit      = h;
        cache_evt.data_returned = r;
        @(negedge core_clk);
        cache_evt.cycle_start   = 1'b0;
        cache_evt.read_hit      = 1'b0;
        cache_evt.data_returned = 1'b0;
    endtask
endmodule

`default_nettype wire

// file: tb/tb_completion_cache_discard_timer.sv
// Self-checking bench for the completion cache discard timer.
// Assumes ccdt_pkg and the master model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("MISMATCH t=%0t got %h exp %h", $time, (got), (exp)); \
        end \
    end

module tb_completion_cache_discard_timer
    import ccdt_pkg::*;
;
    logic         core_clk = 1'b0;
    logic         rst_b    = 1'b0;
    logic         fund_b   = 1'b1;
    logic         glob_b   = 1'b1;
    logic [1:0]   policy   = 2'b01;
    cfg_access_t  cfg_in   = '0;
    cache_event_t evt;
    logic [15:0]  rdata;
    logic         ack;
    logic         discard;
    int           n_mismatch = 0;
    int           compares   = 0;
    int           disc_cnt   = 0;
    int           n;

    always #2 core_clk = ~core_clk;

    always @(posedge core_clk)
    begin
        // An unknown counts as a pulse so that it cannot pass unseen
        if (discard !== 1'b0)
            disc_cnt++;
    end

    completion_cache_discard_timer DUT (
        .core_clk                  (core_clk),
        .rst_b                     (rst_b),
        .pcie_fund_reset_b         (fund_b),
        .global_reset_input_b      (glob_b),
        .completion_caching_policy (policy),
        .cache_evt                 (evt),
        .cfg_in                    (cfg_in),
        .cfg_rdata_ff              (rdata),
        .cfg_ack_ff                (ack),
        .discard_ff                (discard)
    );

    pci_master_model pm (
        .core_clk  (core_clk),
        .cache_evt (evt)
    );

    task automatic give_verdict();
        if (n_mismatch == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Request at a falling edge, ack looked at one cycle later, then one idle cycle
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
                       input logic [1:0] lanes, output logic [15:0] r);
        cfg_in = '{req: 1'b1, wr: w, addr: a, be: lanes, wdata: d};
        @(negedge core_clk);
        r = rdata;
        `CHK(ack, 1'b1)
        cfg_in = '0;
        @(negedge core_clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] r;
        acc(1'b0, a, 16'h0000, 2'b11, r);
        `CHK(r, e)
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] r;
        acc(1'b1, a, d, 2'b11, r);
    endtask

    // Cycles until a discard pulse, 0 when none within cap
    task automatic watch(input int cap, output int k);
        k = 0;
        for (int i = 1; i <= cap && k == 0; i++)
        begin
            @(negedge core_clk);
            if (discard !== 1'b0)
                k = i;
        end
    endtask

    task automatic t_regs();
        logic [15:0] r;
        rd_chk(8'hea, 16'h0008);
        rd_chk(8'hec, 16'h007f);
        rd_chk(8'hee, 16'h01c0);
        wr(8'hea, 16'hffff);
        wr(8'hec, 16'hffff);
        wr(8'hee, 16'hffff);
        wr(8'he8, 16'hffff);
        rd_chk(8'hea, 16'h00ff);
        rd_chk(8'hec, 16'h0fff);
        rd_chk(8'hee, 16'h0fff);
        rd_chk(8'he8, 16'h0000);
        // A single byte lane leaves the other lane alone
        acc(1'b1, 8'hec, 16'h0000, 2'b01, r);
        acc(1'b1, 8'hee, 16'h0000, 2'b10, r);
        rd_chk(8'hec, 16'h0f00);
        rd_chk(8'hee, 16'h00ff);
    endtask

    task automatic t_upper();
        int d0;
        policy = 2'b11;
        wr(8'hee, 16'h0010);
        pm.set_valid(1'b1);
        watch(24, n);
        `CHK(n, 18)
        pm.set_valid(1'b0);
        repeat (3) @(negedge core_clk);
        d0 = disc_cnt;
        pm.set_valid(1'b1);
        repeat (4)
        begin
            repeat (10) @(negedge core_clk);
            pm.pulse(1'b0, 1'b1, 1'b0);
        end
        `CHK(disc_cnt, d0)
        watch(24, n);
        `CHK(n, 17)
        pm.set_valid(1'b0);
        policy = 2'b01;
        repeat (3) @(negedge core_clk);
    endtask

    task automatic t_count();
        int d0;
        policy = 2'b10;
        wr(8'hea, 16'h0003);
        wr(8'hec, 16'h0010);
        wr(8'hee, 16'h0fff);
        d0 = disc_cnt;
        pm.set_valid(1'b1);
        repeat (2) @(negedge core_clk);
        pm.pulse(1'b1, 1'b0, 1'b0);
        pm.pulse(1'b1, 1'b0, 1'b0);
        repeat (16) @(negedge core_clk);
        `CHK(disc_cnt, d0)
        pm.pulse(1'b1, 1'b0, 1'b0);
        watch(3, n);
        `CHK(n, 1)
        pm.set_valid(1'b0);
        repeat (3) @(negedge core_clk);
        // Count reached early: the lower timer alone decides the discard
        pm.set_valid(1'b1);
        repeat (2) @(negedge core_clk);
        repeat (3) pm.pulse(1'b1, 1'b0, 1'b0);
        watch(20, n);
        `CHK(n, 13)
        pm.set_valid(1'b0);
        policy = 2'b01;
        repeat (3) @(negedge core_clk);
    endtask

    task automatic t_mode0();
        policy = 2'b00;
        pm.set_valid(1'b1);
        watch(6, n);
        `CHK(n, 0)
        pm.pulse(1'b0, 1'b0, 1'b1);
        // The pulse stands only in the cycle the task returns in
        `CHK(discard, 1'b1)
        pm.set_valid(1'b0);
        policy = 2'b01;
        repeat (3) @(negedge core_clk);
    endtask

    // Either reset pin, or the power-on reset, reloads the limits
    task automatic t_pin(input int sel);
        wr(8'hea, 16'h0055);
        if (sel == 2)
            rst_b = 1'b0;
        else if (sel == 1)
            glob_b = 1'b0;
        else
            fund_b = 1'b0;
        repeat (6) @(negedge core_clk);
        rst_b  = 1'b1;
        glob_b = 1'b1;
        fund_b = 1'b1;
        repeat (6) @(negedge core_clk);
        rd_chk(8'hea, 16'h0008);
        rd_chk(8'hec, 16'h007f);
        rd_chk(8'hee, 16'h01c0);
    endtask

    initial
    begin
        repeat (6) @(negedge core_clk);
        rst_b = 1'b1;
        t_regs();
        t_upper();
        t_count();
        t_mode0();
        t_pin(0);
        t_pin(1);
        t_pin(2);
        give_verdict();
    end

    // Whole run is some hundreds of cycles; this is far beyond it
    initial
    begin
        #20000;
        n_mismatch++;
        give_verdict();
    end
endmodule

`default_nettype wire
